// >>> rtl/qfr_pkg.sv
// What this block does
// - Acts only as controller; drives serial clock and chip select itself.
// - Reads over one, two or four data lines, chosen by software.
// - Direct memory read port hides command, address and data phases.
// - Word length programmable from one to 128 bits.
// - Words per frame programmable from one to 4096.
// - Works with 3-pin, 4-pin or 6-pin wiring.
// - Optional interrupt on word completion or on frame completion.
// - Zero to three extra serial clock periods, clock held low, between select and first data.
// - Clock mode 0 only: clock idles low, phase zero.
// - Read data sampled on falling serial clock edges.
// - Select active delay-plus-two periods before the first falling edge.
// - Select released two periods after the final falling edge.
// - Output data changes on falling serial clock edges.
// - Divide value zero or odd gives equal high and low time.
// - Suited to fast boot reads from quad serial flash.
package qfr_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int DIV_W      = 8;
  localparam int WORD_MAX   = 128;
  localparam int LEN_W      = 7;
  localparam int CNT_W      = 12;
  localparam int DLY_W      = 2;
  localparam int LANES      = 4;
  localparam int MEM_CMD_W  = 8;
  localparam int MEM_ADDR_W = 24;
  localparam int MEM_DATA_W = 32;

  // ----------------------------------------
  // Timing counts in serial clock periods; MIN_PERIOD in system clock cycles
  // ----------------------------------------
  localparam logic [DLY_W-1:0] LEAD_EXTRA     = 2'h1;
  localparam logic [1:0]       TRAIL_PERIODS  = 2'h2;
  localparam logic [DIV_W:0]   MIN_PERIOD     = 9'h002;

  // ----------------------------------------
  // Fixed word lengths of the memory read, and the longest word length
  // ----------------------------------------
  localparam logic [7:0] MEM_HDR_BITS  = 8'h20;
  localparam logic [7:0] MEM_READ_BITS = 8'h20;
  localparam logic [7:0] WORD_MAX_BITS = 8'h80;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {QFR_SINGLE, QFR_DUAL, QFR_QUAD} qfr_lanes_t;

  typedef struct packed {
    logic [DIV_W-1:0]     serial_clock_divide_value;
    logic [DLY_W-1:0]     chip_select_data_delay;
    qfr_lanes_t           lanes;
    logic                 three_pin;
    logic                 write;
    logic [LEN_W-1:0]     word_len_m1;
    logic [CNT_W-1:0]     word_cnt_m1;
    logic                 word_irq_en;
    logic                 frame_irq_en;
    logic [MEM_CMD_W-1:0] mem_read_cmd;
  } qfr_cfg_t;

  typedef struct packed {
    logic busy;
    logic word_done;
    logic frame_done;
  } qfr_status_t;

endpackage

// >>> rtl/qfr_sclk_gen.sv
`timescale 1ns/100ps
module qfr_sclk_gen #(
  parameter int DIV_W = qfr_pkg::DIV_W
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] div,
  output logic                  rise_tick,
  output logic                  fall_tick
);
  import qfr_pkg::*;

  // ----------------------------------------
  // Period and phase lengths
  // ----------------------------------------
  logic [DIV_W:0] period;
  logic [DIV_W:0] high_len;
  logic [DIV_W:0] low_len;
  logic [DIV_W:0] cnt;

  always_comb begin
    period   = (div == '0) ? MIN_PERIOD : ({1'b0, div} + 1'b1);
    high_len = period >> 1;
    low_len  = period - high_len;
  end

  // ----------------------------------------
  // Phase counter, restarts whenever stopped
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
    end else if (!run || fall_tick) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  assign rise_tick = run && (cnt == low_len - 1'b1);
  assign fall_tick = run && (cnt == period - 1'b1);

endmodule // qfr_sclk_gen

// >>> rtl/qfr_quad_serial_flash_reader.sv
`timescale 1ns/100ps
module qfr_quad_serial_flash_reader #(
  parameter int DIV_W = qfr_pkg::DIV_W
) (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire qfr_pkg::qfr_cfg_t             cfg,
  input  wire logic                          start,
  input  wire logic [qfr_pkg::WORD_MAX-1:0]  tx_word,
  output logic                               tx_take,
  output logic [qfr_pkg::WORD_MAX-1:0]       rx_word,
  input  wire logic                          mem_req,
  input  wire logic [qfr_pkg::MEM_ADDR_W-1:0] mem_addr,
  output logic                               mem_ack,
  output logic [qfr_pkg::MEM_DATA_W-1:0]     mem_rdata,
  output qfr_pkg::qfr_status_t               status,
  output logic                               word_irq,
  output logic                               frame_irq,
  output logic                               cs_n,
  output logic                               sclk,
  input  wire logic [qfr_pkg::LANES-1:0]     d_in,
  output logic [qfr_pkg::LANES-1:0]          d_out,
  output logic [qfr_pkg::LANES-1:0]          d_oe
);
  import qfr_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TRAIL} qfr_state_t;

  // ----------------------------------------
  // State
  // ----------------------------------------
  qfr_state_t            state;
  qfr_cfg_t              cfg_q;
  logic                  mem_mode;
  logic [MEM_ADDR_W-1:0] addr_q;
  logic [DLY_W-1:0]      lead_cnt;
  logic [1:0]            trail_cnt;
  logic [CNT_W-1:0]      word_idx;
  logic [7:0]            bit_cnt;
  logic [7:0]            cur_len;
  logic                  cur_write;
  logic [WORD_MAX-1:0]   shreg;
  logic [WORD_MAX-1:0]   rx_acc;
  logic                  rise_tick;
  logic                  fall_tick;

  // ----------------------------------------
  // Serial clock timing
  // ----------------------------------------
  qfr_sclk_gen #(
    .DIV_W (DIV_W)
  ) u_sclk_gen (
    .clk       (clk),
    .resetn    (resetn),
    .run       (state != ST_IDLE),
    .div       (cfg_q.serial_clock_divide_value),
    .rise_tick (rise_tick),
    .fall_tick (fall_tick)
  );

  // ----------------------------------------
  // Per-beat decode
  // ----------------------------------------
  logic [2:0]          step;
  logic [LANES-1:0]    sample;
  logic [WORD_MAX-1:0] next_rx;
  logic [7:0]          done_bits;
  logic                word_end;
  logic                last_word;
  logic [7:0]          frame_len;
  logic                next_write;
  logic [7:0]          next_len;
  logic [WORD_MAX-1:0] next_data;

  always_comb begin
    sample = d_in;
    if (cur_write) begin
      step    = 3'h1;
      next_rx = rx_acc;
    end else begin
      unique case (cfg_q.lanes)
        QFR_SINGLE: begin
          step    = 3'h1;
          next_rx = {rx_acc[WORD_MAX-2:0], cfg_q.three_pin ? sample[0] : sample[1]};
        end
        QFR_DUAL: begin
          step    = 3'h2;
          next_rx = {rx_acc[WORD_MAX-3:0], sample[1:0]};
        end
        QFR_QUAD: begin
          step    = 3'h4;
          next_rx = {rx_acc[WORD_MAX-5:0], sample[3:0]};
        end
        default: begin
          step    = 3'h4;
          next_rx = {rx_acc[WORD_MAX-5:0], sample[3:0]};
        end
      endcase
    end
    done_bits = bit_cnt + {5'h0, step};
    word_end  = (done_bits >= cur_len);
    last_word = mem_mode ? (word_idx == 12'h001) : (word_idx == cfg_q.word_cnt_m1);
    frame_len = {1'b0, cfg_q.word_len_m1} + 8'h01;
  end

  // Next word of the frame, loaded at a word boundary
  always_comb begin
    if (mem_mode) begin
      next_write = 1'b0;
      next_len   = MEM_READ_BITS;
      next_data  = '0;
    end else begin
      next_write = cfg_q.write;
      next_len   = frame_len;
      next_data  = tx_word << (WORD_MAX_BITS - frame_len);
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state     <= ST_IDLE;
      lead_cnt  <= '0;
      trail_cnt <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (mem_req || start) begin
            state    <= ST_LEAD;
            lead_cnt <= '0;
          end
        end
        ST_LEAD: begin
          if (fall_tick) begin
            if (lead_cnt == cfg_q.chip_select_data_delay) begin
              state <= ST_SHIFT;
            end else begin
              lead_cnt <= lead_cnt + LEAD_EXTRA;
            end
          end
        end
        ST_SHIFT: begin
          if (fall_tick && word_end && last_word) begin
            state     <= ST_TRAIL;
            trail_cnt <= '0;
          end
        end
        ST_TRAIL: begin
          if (fall_tick) begin
            if (trail_cnt == TRAIL_PERIODS - 2'h1) begin
              state <= ST_IDLE;
            end else begin
              trail_cnt <= trail_cnt + 2'h1;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Frame setup, latched at start
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q    <= '0;
      mem_mode <= 1'b0;
      addr_q   <= '0;
    end else if (state == ST_IDLE && (mem_req || start)) begin
      cfg_q    <= cfg;
      mem_mode <= mem_req;
      addr_q   <= mem_addr;
    end
  end

  // ----------------------------------------
  // Word and bit bookkeeping, shift registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      word_idx  <= '0;
      bit_cnt   <= '0;
      cur_len   <= '0;
      cur_write <= 1'b0;
      shreg     <= '0;
      rx_acc    <= '0;
    end else if (state == ST_IDLE && (mem_req || start)) begin
      word_idx <= '0;
      bit_cnt  <= '0;
      rx_acc   <= '0;
      if (mem_req) begin
        cur_write <= 1'b1;
        cur_len   <= MEM_HDR_BITS;
        shreg     <= {cfg.mem_read_cmd, mem_addr, {(WORD_MAX - MEM_CMD_W - MEM_ADDR_W){1'b0}}};
      end else begin
        cur_write <= cfg.write;
        cur_len   <= {1'b0, cfg.word_len_m1} + 8'h01;
        shreg     <= tx_word << (WORD_MAX_BITS - ({1'b0, cfg.word_len_m1} + 8'h01));
      end
    end else if (state == ST_SHIFT && fall_tick) begin
      if (word_end) begin
        word_idx  <= word_idx + 1'b1;
        bit_cnt   <= '0;
        rx_acc    <= '0;
        cur_write <= next_write;
        cur_len   <= next_len;
        shreg     <= next_data;
      end else begin
        bit_cnt <= done_bits;
        rx_acc  <= next_rx;
        shreg   <= shreg << 1;
      end
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs_n <= 1'b1;
    end else if (state == ST_IDLE && (mem_req || start)) begin
      cs_n <= 1'b0;
    end else if (state == ST_TRAIL && fall_tick && trail_cnt == TRAIL_PERIODS - 2'h1) begin
      cs_n <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk <= 1'b0;
    end else if (state == ST_SHIFT && rise_tick) begin
      sclk <= 1'b1;
    end else if (fall_tick || state != ST_SHIFT) begin
      sclk <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      d_out <= '0;
      d_oe  <= '0;
    end else if (state == ST_LEAD && fall_tick && lead_cnt == cfg_q.chip_select_data_delay) begin
      d_out <= {3'h0, shreg[WORD_MAX-1]};
      d_oe  <= {3'h0, cur_write};
    end else if (state == ST_SHIFT && fall_tick) begin
      if (word_end && last_word) begin
        d_out <= '0;
        d_oe  <= '0;
      end else if (word_end) begin
        d_out <= {3'h0, next_data[WORD_MAX-1]};
        d_oe  <= {3'h0, next_write};
      end else begin
        d_out <= {3'h0, shreg[WORD_MAX-2]};
        d_oe  <= {3'h0, cur_write};
      end
    end else if (state == ST_IDLE) begin
      d_out <= '0;
      d_oe  <= '0;
    end
  end

  // ----------------------------------------
  // Results and events
  // ----------------------------------------
  logic word_evt;
  logic frame_evt;

  always_comb begin
    word_evt  = (state == ST_SHIFT) && fall_tick && word_end;
    frame_evt = (state == ST_TRAIL) && fall_tick && (trail_cnt == TRAIL_PERIODS - 2'h1);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_word   <= '0;
      mem_rdata <= '0;
    end else if (word_evt && !cur_write) begin
      rx_word <= next_rx;
      if (mem_mode) begin
        mem_rdata <= next_rx[MEM_DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_take <= 1'b0;
    end else begin
      tx_take <= (state == ST_IDLE && start && !mem_req) || (word_evt && !last_word && !mem_mode);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      word_irq  <= 1'b0;
      frame_irq <= 1'b0;
      mem_ack   <= 1'b0;
    end else begin
      word_irq  <= word_evt && cfg_q.word_irq_en;
      frame_irq <= frame_evt && cfg_q.frame_irq_en;
      mem_ack   <= frame_evt && mem_mode;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status <= '0;
    end else begin
      status.busy       <= (state != ST_IDLE && !frame_evt) || mem_req || start;
      status.word_done  <= word_evt;
      status.frame_done <= frame_evt;
    end
  end

endmodule // qfr_quad_serial_flash_reader

// >>> verification/qfr_properties.sv
`timescale 1ns/100ps
module qfr_properties (
  input wire logic                       clk,
  input wire logic                       resetn,
  input wire qfr_pkg::qfr_cfg_t          cfg,
  input wire qfr_pkg::qfr_status_t       status,
  input wire logic                       mem_ack,
  input wire logic                       word_irq,
  input wire logic                       frame_irq,
  input wire logic                       cs_n,
  input wire logic                       sclk,
  input wire logic [qfr_pkg::LANES-1:0]  d_out,
  input wire logic [qfr_pkg::LANES-1:0]  d_oe
);
  import qfr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Setup held by the frame in flight
  // ----------------------------------------
  qfr_cfg_t frame_cfg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_cfg <= '0;
    end else if (cs_n) begin
      frame_cfg <= cfg;
    end
  end
  // ----------------------------------------
  // Pin relations
  // ----------------------------------------
  idle_clock_low_a: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  one_lane_out_a: assert property (d_oe[3:1] == 3'h0)
    else $error("upper data pin driven");
  drive_selected_a: assert property (d_oe[0] |-> !cs_n)
    else $error("data driven while deselected");
  out_on_fall_a: assert property (d_oe[0] && $past(d_oe[0]) && $changed(d_out[0]) |-> $fell(sclk))
    else $error("output data changed off a falling edge");
  frame_end_a: assert property ($rose(cs_n) |-> status.frame_done && $past(sclk, 2) == 1'b0)
    else $error("select released badly");
  mem_ack_end_a: assert property (mem_ack |-> $rose(cs_n))
    else $error("memory answer off frame end");
  word_irq_gate_a: assert property (word_irq == (status.word_done && frame_cfg.word_irq_en))
    else $error("word interrupt mismatch");
  frame_irq_gate_a: assert property (frame_irq == (status.frame_done && frame_cfg.frame_irq_en))
    else $error("frame interrupt mismatch");
  busy_in_frame_a: assert property (!cs_n |-> status.busy)
    else $error("selected while not busy");
endmodule // qfr_properties

bind qfr_quad_serial_flash_reader qfr_properties u_qfr_properties (.clk(clk), .resetn(resetn), .cfg(cfg),
  .status(status), .mem_ack(mem_ack), .word_irq(word_irq), .frame_irq(frame_irq), .cs_n(cs_n), .sclk(sclk),
  .d_out(d_out), .d_oe(d_oe));

// >>> verification/qfr_flash_model.sv
`timescale 1ns/100ps
module qfr_flash_model (
  input  wire logic                 cs_n,
  input  wire logic                 sclk,
  input  wire qfr_pkg::qfr_lanes_t  lanes,
  input  wire logic [7:0]           skip,
  input  wire logic [31:0]          pattern,
  output logic [3:0]                dq
);
  import qfr_pkg::*;
  logic [31:0] sh;
  logic [7:0]  n;
  logic [3:0]  q;
  always @(negedge cs_n) begin
    sh = pattern;
    n = 8'h00;
  end
  // Launch next bits on falling clock after the header
  always @(negedge sclk) begin
    if (!cs_n) begin
      if (n >= skip) sh = sh << ((lanes == QFR_SINGLE) ? 1 : (lanes == QFR_DUAL) ? 2 : 4);
      n = n + 8'h01;
    end
  end
  assign q = (lanes == QFR_SINGLE) ? {~sh[31], ~sh[31], sh[31], sh[31]} :
             (lanes == QFR_DUAL) ? {~sh[31:30], sh[31:30]} : sh[31:28];
  // Released lines show the inverse value
  assign dq = cs_n ? ~q : q;
endmodule // qfr_flash_model

// >>> verification/qfr_quad_serial_flash_reader_tb.sv
`timescale 1ns/100ps
module qfr_quad_serial_flash_reader_tb;
  import qfr_pkg::*;
  logic                  clk, resetn, start, mem_req, tx_take, mem_ack, word_irq, frame_irq, cs_n, sclk, ps;
  qfr_cfg_t              cfg;
  qfr_status_t           status;
  logic [WORD_MAX-1:0]   tx_word, rx_word, got, msk;
  logic [MEM_ADDR_W-1:0] mem_addr;
  logic [31:0]           mem_rdata, pat, lfsr;
  logic [3:0]            d_in, d_out, d_oe, flash_d;
  logic [7:0]            skip;
  int                    n_mismatch, n_compared, cyc, t_on, t_off, rises, wds, fis, ack, p, nb, tks;
  assign d_in = (d_oe & d_out) | (~d_oe & flash_d);
  qfr_quad_serial_flash_reader u_qfr_quad_serial_flash_reader (.clk(clk), .resetn(resetn), .cfg(cfg),
    .start(start), .tx_word(tx_word), .tx_take(tx_take), .rx_word(rx_word), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .status(status), .word_irq(word_irq),
    .frame_irq(frame_irq), .cs_n(cs_n), .sclk(sclk), .d_in(d_in), .d_out(d_out), .d_oe(d_oe));
  qfr_flash_model u_qfr_flash_model (.cs_n(cs_n), .sclk(sclk), .lanes(cfg.lanes), .skip(skip),
    .pattern(pat), .dq(flash_d));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int per(input logic [7:0] d);
    return (d == 8'h00) ? 2 : int'(d) + 1;
  endfunction
  task automatic check(input logic [127:0] g, input logic [127:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic run(input logic mem);
    cyc = 0; t_on = 0; t_off = 0; rises = 0; wds = 0; fis = 0; ack = 0; ps = 0; got = '0;
    @(negedge clk);
    start = !mem;
    mem_req = mem;
    @(negedge clk);
    tks = int'(tx_take);
    start = 0;
    mem_req = 0;
    do begin
      @(posedge clk);
      #1;
      cyc++;
      if (d_oe[0] && t_on == 0) t_on = cyc;
      if (!d_oe[0] && t_on != 0 && t_off == 0) t_off = cyc;
      if (sclk && !ps) begin
        rises++;
        got = {got[126:0], d_out[0]};
      end
      ps = sclk;
      wds += int'(word_irq);
      fis += int'(frame_irq);
      ack += int'(mem_ack);
      tks += int'(tx_take);
    end while (!cs_n && cyc < 20000);
    if (cyc >= 20000) check(1, 0);
    @(negedge clk);
  endtask
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    resetn = 0; start = 0; mem_req = 0; cfg = '0; tx_word = '0; mem_addr = '0; pat = '0; skip = 8'h00;
    lfsr = 32'h10aa; n_mismatch = 0; n_compared = 0;
    repeat (16) @(negedge clk);
    resetn = 1;
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      cfg.serial_clock_divide_value = (i < 2) ? 8'(i) : (i == 2) ? 8'h04 : {4'h0, lfsr[3:1], 1'b1};
      cfg.chip_select_data_delay = 2'(i);
      cfg.write = 1;
      cfg.word_len_m1 = (i == 11) ? 7'h7f : (i == 10) ? 7'h00 : {3'h0, lfsr[9:6]};
      cfg.word_cnt_m1 = {10'h000, lfsr[11:10]};
      cfg.word_irq_en = lfsr[12];
      cfg.frame_irq_en = lfsr[13];
      tx_word = {4{lfsr}};
      p = per(cfg.serial_clock_divide_value);
      msk = {128{1'b1}} >> (7'h7f - cfg.word_len_m1);
      run(0);
      check(t_on, (int'(cfg.chip_select_data_delay) + 1) * p);
      check(cyc - t_off, 2 * p);
      check(rises, (int'(cfg.word_len_m1) + 1) * (int'(cfg.word_cnt_m1) + 1));
      check(got & msk, tx_word & msk);
      check(wds, cfg.word_irq_en ? int'(cfg.word_cnt_m1) + 1 : 0);
      check(fis, int'(cfg.frame_irq_en));
      check(tks, int'(cfg.word_cnt_m1) + 1);
    end
    for (int k = 0; k < 5; k++) begin
      lfsr = lfsr_next(lfsr);
      cfg.write = 0;
      cfg.lanes = qfr_lanes_t'((k == 3) ? 2'h0 : (k == 4) ? 2'h3 : 2'(k));
      cfg.three_pin = (k == 3);
      cfg.word_len_m1 = 7'h1f;
      cfg.word_cnt_m1 = '0;
      cfg.mem_read_cmd = lfsr[31:24];
      pat = lfsr;
      skip = 8'h00;
      run(0);
      check(rx_word[31:0], pat);
      check(tks, 1);
      lfsr = lfsr_next(lfsr);
      pat = lfsr;
      mem_addr = lfsr[23:0];
      skip = 8'h20;
      nb = (k == 1) ? 16 : (k == 2 || k == 4) ? 8 : 32;
      run(1);
      check(mem_rdata, pat);
      check(ack, 1);
      check(tks, 0);
      check((got >> nb) & 128'hffffffff, {cfg.mem_read_cmd, mem_addr});
    end
    end_of_test();
  end
endmodule // qfr_quad_serial_flash_reader_tb
